/* File: nested_interrupt_arbiter.sv */
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
// Functional notes
// - Acknowledge in nested mode pushes level, loads new
// - Entry clears enable, saves level in nested mode, pushes frame, vectors
// - Entry loads code segment or uses irq segment
// - Return pops frame, sets enable, restores level in nested mode
// - Return resumes code segment unless still nested
// - Eight external inputs map to four channel pairs
// - Edge select picks rising or falling trigger
// - Each external channel has its own mask
// - Pair priority: even level, odd next level
// - Channel A0 source pin or timer watchdog
// - Channel B0 source pin or serial peripheral
// - Channel C0 source pin or standard timer
// - Channel D0 source pin or clock reset unit
// - Top-level source pin or watchdog end count
// - Top-level pin edge chosen by edge bit
// - Top-level event sets top-level pending bit
// - Maskable top-level path also needs global enable
// - Non-maskable enable is set-only, reset clears
// - Top-level routine blocks every other grant
// - Top-level handling leaves enable, level, stack alone
// - Acknowledge only strictly more urgent than level
// - Acknowledge clears pending; software can set it
module nested_interrupt_arbiter
  import irq_arb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sources
  input wire logic [7:0] ext_input,
  input wire logic nmi_pin,
  input wire logic wdt_irq,
  input wire logic wdt_end_count,
  input wire logic spi_irq,
  input wire logic standard_timer_irq,
  input wire logic clock_reset_unit_irq,
  input wire logic dma_req,
  // CPU core side
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic iret_instr,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] stack_pop_data,
  output logic irq_cycle_busy,
  output logic [7:0] stack_push_data,
  output logic stack_push,
  output logic stack_pop,
  output logic [15:0] vector_out,
  output logic vector_load,
  output logic [7:0] code_segment_reg,
  output logic [7:0] irq_segment_reg,
  output logic use_irq_segment,
  output logic [3:0] ack_channel,
  output logic dma_grant
);

  // Control registers
  logic [7:0] central_ctl_reg; // Pending, enables, mode and current level
  logic [7:0] edge_reg; // Rising or falling trigger per channel
  logic [7:0] pend_reg; // Channel pending flags
  logic [7:0] prio_reg; // Two level bits per pair
  logic [7:0] evec_reg; // Top-level and shared source selects
  logic [6:0] nstk_reg; // Saved levels, one bit per level
  logic tl_nonmask_reg; // Set-only top-level enable
  logic [7:0] mask_reg; // Channel unmask bits
  logic [7:0] cpuc_reg; // Segment push and source selects
  // Previous input levels for edge detection
  logic [7:0] ext_q_reg;
  logic nmi_q_reg;
  logic wdt_eoc_q_reg;
  // Top-level routine in progress
  logic tl_active_reg;
  logic [2:0] in_nest_reg;
  seq_state_t state_reg;
  logic [2:0] pop_cnt_reg;
  logic tl_entry_reg;
  logic [15:0] pc_reg;
  logic [7:0] flags_reg;
  logic [3:0] grant_reg;
  logic [15:0] ret_pc_reg;

  // Lowest set bit: the level saved last, since nesting only goes more urgent
  function automatic logic [2:0] top_of(input logic [6:0] stk);
    logic [2:0] r;
    r = 3'd7;
    for (int i = 6; i >= 0; i--) begin
      if (stk[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Channel request after source select; edges on the synchronous inputs
  wire [7:0] rise = ext_input & ~ext_q_reg;
  wire [7:0] fall = ~ext_input & ext_q_reg;
  wire [7:0] pin_evt = (edge_reg & rise) | (~edge_reg & fall);
  wire b0_ext = ~cpuc_reg[CPUC_SER_EN] & ~cpuc_reg[CPUC_SER_MODE];
  wire [7:0] src_evt = {pin_evt[7],
    evec_reg[EVEC_D0S] ? clock_reset_unit_irq : pin_evt[6],
    pin_evt[5],
    cpuc_reg[CPUC_C0S] ? pin_evt[4] : standard_timer_irq,
    pin_evt[3],
    b0_ext ? pin_evt[2] : spi_irq,
    pin_evt[1],
    evec_reg[EVEC_A0S] ? pin_evt[0] : wdt_irq};

  // Top-level event
  wire nmi_evt = evec_reg[EVEC_TL_EDGE] ? (nmi_pin & ~nmi_q_reg) : (~nmi_pin & nmi_q_reg);
  wire wdt_evt = wdt_end_count & ~wdt_eoc_q_reg;
  wire tl_evt = evec_reg[EVEC_TL_SRC] ? nmi_evt : wdt_evt;
  wire irq_en = central_ctl_reg[CTL_IRQ_EN];
  wire [2:0] cur_level = central_ctl_reg[2:0];
  wire tl_mask_path = central_ctl_reg[CTL_TL_MASK_EN] & irq_en;
  wire tl_req = central_ctl_reg[CTL_TL_PEND] & (tl_mask_path | tl_nonmask_reg);

  // Priority of each channel: even gets 2*pair, odd next
  logic [2:0] ch_prl [8];
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      ch_prl[c] = {prio_reg[2*(c/2)+1], prio_reg[2*(c/2)], 1'(c % 2)};
    end
  end

  // Pick most urgent masked request; lower channel wins ties
  logic win_vld;
  logic [2:0] win_ch;
  logic [2:0] win_prl;
  always_comb begin
    win_vld = 1'b0;
    win_ch = 3'd0;
    win_prl = 3'd7;
    for (int c = 7; c >= 0; c--) begin
      if (pend_reg[c] && mask_reg[c] && ch_prl[c] <= win_prl) begin
        win_vld = 1'b1;
        win_ch = 3'(c);
        win_prl = ch_prl[c];
      end
    end
  end

  wire idle = (state_reg == ST_IDLE) & ~iret_instr & (pop_cnt_reg == 3'd0);
  wire block = tl_active_reg;
  wire grant_tl = idle & ~block & tl_req;
  wire grant_ch = idle & ~block & ~tl_req & irq_en & win_vld & (win_prl < cur_level);
  wire nested = central_ctl_reg[CTL_ARB_MODE];
  wire segp = cpuc_reg[CPUC_SEGP];
  assign dma_grant = dma_req & ~block & idle & ~grant_tl & ~grant_ch;

  // Wishbone decode
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire [7:0] wa = wb_adr_i[9:2];
  wire wr_central = wb_wr & (wa == CENTRAL_IDX);
  wire wr_pend = wb_wr & (wa == PEND_IDX);
  logic [7:0] rd_mux;
  always_comb begin
    case (wa)
      CENTRAL_IDX: rd_mux = central_ctl_reg;
      EDGE_IDX: rd_mux = edge_reg;
      PEND_IDX: rd_mux = pend_reg;
      PRIO_IDX: rd_mux = prio_reg;
      EVEC_IDX: rd_mux = evec_reg;
      NSTK_IDX: rd_mux = {tl_nonmask_reg, nstk_reg};
      MASK_IDX: rd_mux = mask_reg;
      CPUC_IDX: rd_mux = cpuc_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Bus answer one cycle after the request
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end

  // Plain software registers and edge history
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_reg <= EDGE_RST;
      prio_reg <= PRIO_RST;
      evec_reg <= EVEC_RST;
      mask_reg <= MASK_RST;
      cpuc_reg <= CPUC_RST;
      ext_q_reg <= 8'h00;
      nmi_q_reg <= 1'b0;
      wdt_eoc_q_reg <= 1'b0;
    end else if (clk_en) begin
      ext_q_reg <= ext_input;
      nmi_q_reg <= nmi_pin;
      wdt_eoc_q_reg <= wdt_end_count;
      if (wb_wr && wa == EDGE_IDX) edge_reg <= wb_dat_i[7:0];
      if (wb_wr && wa == PRIO_IDX) prio_reg <= wb_dat_i[7:0];
      if (wb_wr && wa == EVEC_IDX) evec_reg <= wb_dat_i[7:0];
      if (wb_wr && wa == MASK_IDX) mask_reg <= wb_dat_i[7:0];
      if (wb_wr && wa == CPUC_IDX) cpuc_reg <= wb_dat_i[7:0];
    end
  end

  // Pending flags: events win over clearing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= 8'h00;
    end else if (clk_en) begin
      pend_reg <= ((wr_pend ? wb_dat_i[7:0] : pend_reg)
                  & ~(grant_ch ? 8'(1 << win_ch) : 8'h00)) | src_evt;
    end
  end

  // Central control, level stack and top-level state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      central_ctl_reg <= CENTRAL_RST;
      nstk_reg <= 7'h00;
      tl_nonmask_reg <= 1'b0;
      tl_active_reg <= 1'b0;
      in_nest_reg <= 3'd0;
    end else if (clk_en) begin
      // Software write first; hardware updates below take precedence
      if (wr_central) central_ctl_reg <= wb_dat_i[7:0];
      if (wb_wr && wa == NSTK_IDX) begin
        nstk_reg <= wb_dat_i[6:0];
        tl_nonmask_reg <= tl_nonmask_reg | wb_dat_i[NSTK_TL_NONMASK];
      end
      if (enable_irq_instr) central_ctl_reg[CTL_IRQ_EN] <= 1'b1;
      if (disable_irq_instr) central_ctl_reg[CTL_IRQ_EN] <= 1'b0;
      if (tl_evt) central_ctl_reg[CTL_TL_PEND] <= 1'b1;
      if (grant_tl) begin
        // Acknowledge clears pending unless a fresh event lands now
        central_ctl_reg[CTL_TL_PEND] <= tl_evt;
        tl_active_reg <= 1'b1;
      end
      if (grant_ch) begin
        central_ctl_reg[CTL_IRQ_EN] <= 1'b0;
        in_nest_reg <= in_nest_reg + 3'd1;
        if (nested) begin
          if (cur_level != 3'd7) nstk_reg[cur_level] <= 1'b1;
          central_ctl_reg[2:0] <= win_prl;
        end
      end
      if (iret_instr && state_reg == ST_IDLE) begin
        if (tl_active_reg) begin
          tl_active_reg <= 1'b0;
        end else begin
          central_ctl_reg[CTL_IRQ_EN] <= 1'b1;
          in_nest_reg <= in_nest_reg - 3'd1;
          if (nested) begin
            central_ctl_reg[2:0] <= top_of(nstk_reg);
            if (top_of(nstk_reg) != 3'd7) nstk_reg[top_of(nstk_reg)] <= 1'b0;
          end
        end
      end
    end
  end

  // Entry and return sequences toward the stack
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      pop_cnt_reg <= 3'd0;
      pc_reg <= 16'h0000;
      flags_reg <= 8'h00;
      grant_reg <= 4'h0;
      tl_entry_reg <= 1'b0;
      ret_pc_reg <= 16'h0000;
      code_segment_reg <= 8'h00;
      irq_segment_reg <= 8'h00;
      use_irq_segment <= 1'b0;
    end else if (clk_en) begin
      if (grant_tl || grant_ch) begin
        state_reg <= ST_PCL;
        pc_reg <= pc_in;
        flags_reg <= flags_in;
        grant_reg <= grant_tl ? 4'h8 : {1'b0, win_ch};
        tl_entry_reg <= grant_tl;
      end
      case (state_reg)
        ST_PCL: state_reg <= ST_PCH;
        ST_PCH: state_reg <= segp ? ST_SEG : ST_FLG;
        ST_SEG: state_reg <= ST_FLG;
        ST_FLG: state_reg <= ST_VEC;
        ST_VEC: begin
          state_reg <= ST_IDLE;
          if (segp) code_segment_reg <= irq_segment_reg;
          else use_irq_segment <= 1'b1;
        end
        default: ;
      endcase
      // Pop order: flags, segment, high, low
      if (iret_instr && state_reg == ST_IDLE) begin
        pop_cnt_reg <= segp ? 3'd4 : 3'd3;
        // Plain code segment again only when no other routine stays open
        if (!segp && (tl_active_reg ? in_nest_reg == 3'd0 : in_nest_reg <= 3'd1)) begin
          use_irq_segment <= 1'b0;
        end
      end else if (pop_cnt_reg != 3'd0) begin
        pop_cnt_reg <= pop_cnt_reg - 3'd1;
        if (segp && pop_cnt_reg == 3'd3) code_segment_reg <= stack_pop_data;
        if (pop_cnt_reg == 3'd2) ret_pc_reg[15:8] <= stack_pop_data;
        if (pop_cnt_reg == 3'd1) ret_pc_reg[7:0] <= stack_pop_data;
      end
      if (wb_wr && wa == ISEG_IDX) irq_segment_reg <= wb_dat_i[7:0];
    end
  end

  // Outputs toward the core
  assign irq_cycle_busy = (state_reg != ST_IDLE) | (pop_cnt_reg != 3'd0);
  assign stack_push = (state_reg == ST_PCL) | (state_reg == ST_PCH)
                    | (state_reg == ST_SEG) | (state_reg == ST_FLG);
  assign stack_push_data = (state_reg == ST_PCL) ? pc_reg[7:0] :
                           (state_reg == ST_PCH) ? pc_reg[15:8] :
                           (state_reg == ST_SEG) ? code_segment_reg : flags_reg;
  assign stack_pop = pop_cnt_reg != 3'd0;
  assign vector_load = state_reg == ST_VEC;
  assign vector_out = {8'h00, 3'b000, grant_reg, 1'b0};
  assign ack_channel = grant_reg;

  // Checks
  a_pend_clear_ack: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && grant_ch && !src_evt[win_ch] |=> !pend_reg[$past(win_ch)])
    else $error("pending not cleared on acknowledge");
  a_nest_level_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && grant_ch && nested && !wr_central |=> cur_level == $past(win_prl))
    else $error("level not loaded");
  a_tl_keeps_ien: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && grant_tl && !wr_central && !enable_irq_instr && !disable_irq_instr
    |=> $stable(central_ctl_reg[4:0]))
    else $error("top-level changed enable or level");
  a_tl_blocks_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tl_active_reg |-> !grant_ch && !grant_tl && !dma_grant)
    else $error("grant during top-level routine");
  a_nonmask_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(tl_nonmask_reg) |-> tl_nonmask_reg)
    else $error("non-maskable enable cleared");
  a_strict_prio: assert property (@(posedge sys_clk) disable iff (!reset_n)
    grant_ch |-> win_prl < cur_level && irq_en)
    else $error("grant not more urgent");
  a_tl_event_pend: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && tl_evt |=> central_ctl_reg[CTL_TL_PEND])
    else $error("top-level pending not set");
  // Entry frame: low byte then high byte, flags then vector
  sequence s_push_front;
    state_reg == ST_PCL ##1 state_reg == ST_PCH;
  endsequence
  sequence s_push_back;
    state_reg == ST_FLG ##1 vector_load;
  endsequence
  a_entry_order: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && (grant_ch || grant_tl) ##1 clk_en |-> s_push_front)
    else $error("entry order wrong");
  a_vector_after_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && state_reg == ST_FLG |-> s_push_back)
    else $error("vector not loaded after flags");
  a_edge_pending: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && pin_evt[1] |=> pend_reg[1])
    else $error("edge did not set pending");
endmodule

/* File: irq_arb_pkg.sv */
package irq_arb_pkg;
  // Register offsets; the bus address is four times the offset
  localparam logic [7:0] CENTRAL_IDX = 8'he6;
  localparam logic [7:0] EDGE_IDX = 8'hf2;
  localparam logic [7:0] PEND_IDX = 8'hf3;
  localparam logic [7:0] PRIO_IDX = 8'hf5;
  localparam logic [7:0] EVEC_IDX = 8'hf6;
  localparam logic [7:0] NSTK_IDX = 8'hf7;
  localparam logic [7:0] MASK_IDX = 8'hf4;
  localparam logic [7:0] CPUC_IDX = 8'hf8;
  localparam logic [7:0] ISEG_IDX = 8'hf9;
  // Reset values
  localparam logic [7:0] CENTRAL_RST = 8'h87;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'hff;
  localparam logic [7:0] EVEC_RST = 8'h06;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CPUC_RST = 8'h00;
  // Field positions
  localparam int CTL_TL_PEND = 6;
  localparam int CTL_TL_MASK_EN = 5;
  localparam int CTL_IRQ_EN = 4;
  localparam int CTL_ARB_MODE = 3;
  localparam int EVEC_TL_EDGE = 3;
  localparam int EVEC_TL_SRC = 2;
  localparam int EVEC_A0S = 1;
  localparam int EVEC_D0S = 0;
  localparam int NSTK_TL_NONMASK = 7;
  localparam int CPUC_SEGP = 0;
  localparam int CPUC_C0S = 1;
  localparam int CPUC_SER_EN = 2;
  localparam int CPUC_SER_MODE = 3;
  // CPU sequence states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PCL = 3'b001,
    ST_PCH = 3'b010,
    ST_SEG = 3'b011,
    ST_FLG = 3'b100,
    ST_VEC = 3'b101
  } seq_state_t;
endpackage

/* File: core_model.sv */
`timescale 1ns/1ps
// Behavioural CPU core: keeps the stack frame and issues returns on request
module core_model
  import irq_arb_pkg::*;
#(
  parameter logic [15:0] PC_VAL = 16'h1234,
  parameter logic [7:0] FLAG_VAL = 8'h5a
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ret_req,
  input wire logic stack_push,
  input wire logic [7:0] stack_push_data,
  input wire logic stack_pop,
  input wire logic vector_load,
  input wire logic [15:0] vector_out,
  output logic iret_instr,
  output logic [15:0] pc_in,
  output logic [7:0] flags_in,
  output logic [7:0] stack_pop_data
);
  // System stack bytes and pointer
  logic [7:0] stk [16];
  logic [3:0] sp;
  // Last vector loaded and how many were loaded
  logic [15:0] last_vec;
  int vec_count;
  // Program counter and flags seen at every grant
  assign pc_in = PC_VAL;
  assign flags_in = FLAG_VAL;
  // Top byte only while popped; inverted otherwise so stale data never matches
  assign stack_pop_data = stack_pop ? stk[sp - 4'h1] : ~stk[sp - 4'h1];
  // Stack, return pulse and vector capture
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp <= 4'h0;
      iret_instr <= 1'b0;
      last_vec <= 16'h0000;
      vec_count <= 0;
    end else begin
      // Only returns are issued inside routines, never re-enables
      iret_instr <= ret_req;
      if (stack_push) begin
        stk[sp] <= stack_push_data;
        sp <= sp + 4'h1;
      end else if (stack_pop) begin
        sp <= sp - 4'h1;
      end
      // Record each vector handed over
      if (vector_load) begin
        last_vec <= vector_out;
        vec_count <= vec_count + 1;
      end
    end
  end
endmodule

/* File: nested_interrupt_arbiter_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the interrupt arbiter
module nested_interrupt_arbiter_tb
  import irq_arb_pkg::*;
;
  // Clock, reset and bus
  logic sys_clk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, stack_push, stack_pop, vector_load, use_irq_segment, dma_grant, iret_instr;
  // Sources and core side
  logic [7:0] ext_input = 8'h00;
  logic nmi_pin = 1'b1, wdt_irq = 1'b0, spi_irq = 1'b0, standard_timer_irq = 1'b0;
  logic clock_reset_unit_irq = 1'b0, dma_req = 1'b0, ret_req = 1'b0, clk_en = 1'b1;
  logic irq_cycle_busy;
  logic [15:0] pc_in, vector_out;
  logic [7:0] flags_in, stack_pop_data, stack_push_data, rd;
  logic [3:0] ack_channel;
  int fail_count = 0, checks = 0, cycles = 0;
  // Rows: offset, write flag, write data, expected read
  typedef struct packed {logic [7:0] off; logic we; logic [7:0] wd; logic [7:0] exp;} row_t;
  row_t rows [12] = '{
    {8'he6, 1'b0, 8'h00, 8'h87}, {8'hf2, 1'b0, 8'h00, 8'h00}, {8'hf3, 1'b0, 8'h00, 8'h00},
    {8'hf4, 1'b0, 8'h00, 8'h00}, {8'hf5, 1'b0, 8'h00, 8'hff}, {8'hf6, 1'b0, 8'h00, 8'h06},
    {8'hf7, 1'b0, 8'h00, 8'h00}, {8'h10, 1'b0, 8'h00, 8'h00}, {8'hf2, 1'b1, 8'ha5, 8'ha5},
    {8'hf4, 1'b1, 8'h5a, 8'h5a}, {8'hf5, 1'b1, 8'h3c, 8'h3c}, {8'h10, 1'b1, 8'hff, 8'h00}};
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  nested_interrupt_arbiter nested_interrupt_arbiter_i (
    .sys_clk, .reset_n, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_input, .nmi_pin, .wdt_irq,
    .wdt_end_count(1'b0), .spi_irq, .standard_timer_irq, .clock_reset_unit_irq, .dma_req,
    .enable_irq_instr(1'b0), .disable_irq_instr(1'b0), .iret_instr, .pc_in, .flags_in,
    .stack_pop_data, .irq_cycle_busy, .stack_push_data, .stack_push, .stack_pop,
    .vector_out, .vector_load, .code_segment_reg(), .irq_segment_reg(), .use_irq_segment,
    .ack_channel, .dma_grant);
  core_model core_model_i (
    .sys_clk, .reset_n, .ret_req, .stack_push, .stack_push_data, .stack_pop, .vector_load,
    .vector_out, .iret_instr, .pc_in, .flags_in, .stack_pop_data);
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic bus(input logic we, input logic [7:0] off, input logic [7:0] wd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {off, 2'b00};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, wd};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1) @(posedge sys_clk);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Read a register and compare
  task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
    bus(1'b0, off, 8'h00);
    check(32'(rd), 32'(exp));
  endtask
  // Return from the running routine and let the frame unwind
  task automatic do_return();
    ret_req <= 1'b1;
    @(posedge sys_clk);
    ret_req <= 1'b0;
    wait (core_model_i.sp == 4'h0);
    repeat (3) @(posedge sys_clk);
  endtask
  // Counts, verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].we) bus(1'b1, rows[i].off, rows[i].wd);
      rdc(rows[i].off, rows[i].exp);
    end
    $display("test registers finished");
    // Pin 3 falls under select 0, pin 5 rises under select 1
    bus(1'b1, 8'hf2, 8'h20);
    ext_input[3] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(8'hf3, 8'h00);
    ext_input[3] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc(8'hf3, 8'h08);
    ext_input[5] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(8'hf3, 8'h28);
    bus(1'b1, 8'hf3, 8'h00);
    rdc(8'hf3, 8'h00);
    $display("test edges finished");
    // A0 from watchdog, B0 from serial, C0 from timer, D0 stays on its pin
    bus(1'b1, 8'hf8, 8'h04);
    bus(1'b1, 8'hf6, 8'h04);
    {wdt_irq, spi_irq, standard_timer_irq, clock_reset_unit_irq} <= 4'hf;
    @(posedge sys_clk);
    {wdt_irq, spi_irq, standard_timer_irq, clock_reset_unit_irq} <= 4'h0;
    repeat (3) @(posedge sys_clk);
    rdc(8'hf3, 8'h15);
    bus(1'b1, 8'hf3, 8'h00);
    bus(1'b1, 8'hf8, 8'h00);
    $display("test sources finished");
    // Level 7 request never wins, level 1 does in nested mode
    bus(1'b1, 8'hf4, 8'h02);
    bus(1'b1, 8'hf5, 8'hff);
    bus(1'b1, 8'he6, 8'h9e);
    bus(1'b1, 8'hf3, 8'h02);
    repeat (10) @(posedge sys_clk);
    check(32'(core_model_i.vec_count), 32'h0);
    bus(1'b1, 8'hf5, 8'hfc);
    wait (core_model_i.vec_count == 1);
    @(negedge sys_clk);
    check(32'(core_model_i.last_vec), 32'h2);
    check(32'(ack_channel), 32'h1);
    check({8'h00, core_model_i.stk[0], core_model_i.stk[1], core_model_i.stk[2]}, 32'h34125a);
    check(32'(use_irq_segment), 32'h1);
    rdc(8'he6, 8'h89);
    rdc(8'hf7, 8'h40);
    rdc(8'hf3, 8'h00);
    do_return();
    rdc(8'he6, 8'h9e);
    rdc(8'hf7, 8'h00);
    check(32'(use_irq_segment), 32'h0);
    $display("test nested finished");
    // Set-only enable, then a falling pin edge starts a top-level routine
    bus(1'b1, 8'hf7, 8'h80);
    bus(1'b1, 8'hf7, 8'h00);
    rdc(8'hf7, 8'h80);
    dma_req <= 1'b1;
    nmi_pin <= 1'b0;
    wait (core_model_i.vec_count == 2);
    @(negedge sys_clk);
    check(32'(core_model_i.last_vec), 32'h10);
    check(32'(ack_channel), 32'h8);
    check(32'(dma_grant), 32'h0);
    rdc(8'he6, 8'h9e);
    rdc(8'hf7, 8'h80);
    do_return();
    rdc(8'he6, 8'h9e);
    check(32'(dma_grant), 32'h1);
    check(32'(use_irq_segment), 32'h0);
    check(32'(irq_cycle_busy), 32'h0);
    $display("test top level finished");
    // Frozen clock enable: a source pulse meanwhile leaves no trace
    clk_en <= 1'b0;
    wdt_irq <= 1'b1;
    @(posedge sys_clk);
    wdt_irq <= 1'b0;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rdc(8'hf3, 8'h00);
    $display("test clock enable finished");
    tally_and_finish();
  end
endmodule
